/* File: bench/ptf_tool_model.sv */
// Receiving tool model: rebuilds message fields from the data-out pins
`timescale 1ns/1ns
module ptf_tool_model (
  input wire logic                    sys_clk, // System clock
  input wire logic                    rst,     // Sync reset, active high
  input wire logic [ptf_pkg::MDO_W-1:0] mdo,   // Message data out
  input wire logic                    mseo_n   // Low inside a field
);
  logic [31:0] acc;       // Field being assembled
  int          nbeat;     // Beats seen in the current field
  logic [31:0] fields[$]; // Finished fields, oldest first

  //////////////////////////////////////////////////////////////////////////
  // Beats arrive least significant byte first; a high beat closes a field.
  // Only the value is kept, so padding above the top set bit is ignored.
  always @(posedge sys_clk) begin
    if (rst) begin
      acc = '0;
      nbeat = 0;
    end else if (mseo_n === 1'b0) begin
      acc = acc | (32'(mdo) << (8 * nbeat));
      nbeat++;
    end else if (nbeat != 0) begin
      fields.push_back(acc);
      acc = '0;
      nbeat = 0;
    end
  end
endmodule

/* File: bench/test_program_trace_sync_message_formatter.sv */
// Self-checking bench for the sync message formatter
`timescale 1ns/1ns
`define PTF_CMP(nm, e, g) begin \
  checks++; \
  if ((e) !== (g)) begin \
    mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); \
  end \
end
module test_program_trace_sync_message_formatter;
  typedef logic [31:0] ptf_exp_t [4];
  logic                            sys_clk = 1'b0;
  logic                            rst = 1'b1;
  logic                            sync_count_select = 1'b0;
  logic                            instr_retire = 1'b0;
  logic                            ev_vld = 1'b0;
  ptf_pkg::ptf_event_t             ev = '0;
  logic                            ev_rdy;
  logic [ptf_pkg::MDO_W-1:0]       mdo;
  logic                            mseo_n;
  logic                            cnt_stall;
  int                              mismatches = 0;
  int                              checks = 0;

  always #2 sys_clk = ~sys_clk;

  ptf_formatter dut (.sys_clk(sys_clk), .rst(rst),
    .sync_count_select(sync_count_select), .instr_retire(instr_retire),
    .ev_vld(ev_vld), .ev(ev), .ev_rdy(ev_rdy), .mdo(mdo),
    .mseo_n(mseo_n), .cnt_stall(cnt_stall));
  ptf_tool_model tool (.sys_clk(sys_clk), .rst(rst), .mdo(mdo),
    .mseo_n(mseo_n));

  //////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the main sequence or any timeout
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic ptf_pkg::ptf_event_t mk(logic ind, logic cmp,
      logic exc, logic [5:0] bp, logic [22:0] tgt, logic canc);
    mk = '{indirect: ind, compressed: cmp, exception: exc, bit_ptr: bp,
           target: tgt, cancelled: canc};
  endfunction

  // Retires are held high for exactly n sampling edges
  task automatic retire(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      instr_retire = 1'b1;
    end
    @(negedge sys_clk);
    instr_retire = 1'b0;
  endtask

  // Bounded wait for fields from the tool, then for the block to idle
  task automatic collect(input string nm, input ptf_exp_t x, input int n);
    int i;
    for (i = 0; i < 400 && tool.fields.size() < n; i++)
      @(negedge sys_clk);
    repeat (8) @(negedge sys_clk);
    for (i = 0; i < 400 && ev_rdy !== 1'b1; i++)
      @(negedge sys_clk);
    if (ev_rdy !== 1'b1 || tool.fields.size() < n) begin
      mismatches++;
      $display("mismatch %s expected done seen timeout", nm);
      summarize();
    end
    `PTF_CMP(nm, n, tool.fields.size())
    for (i = 0; i < n; i++)
      `PTF_CMP(nm, x[i], tool.fields[i])
    tool.fields.delete();
  endtask

  // Retire, offer one event, optionally flip the select after take
  task automatic run_msg(input string nm, input logic sel,
      input logic flip, input ptf_pkg::ptf_event_t e, input int nret,
      input ptf_exp_t x, input int n);
    int i;
    retire(nret);
    sync_count_select = sel;
    ev = e;
    ev_vld = 1'b1;
    for (i = 0; i < 50 && ev_rdy !== 1'b1; i++)
      @(negedge sys_clk);
    // An event that is never taken ends the run as a failure
    if (ev_rdy !== 1'b1) begin
      mismatches++;
      $display("mismatch %s expected ev_rdy seen timeout", nm);
      summarize();
    end
    @(negedge sys_clk);
    ev_vld = 1'b0;
    if (flip)
      sync_count_select = ~sel;
    collect(nm, x, n);
    sync_count_select = sel;
    $display("test %s done", nm);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_plain();
    run_msg("dir_plain", 1'b0, 1'b0, mk(0, 0, 0, 6'h00, 23'h12345, 1), 4,
      '{32'h0B, 32'h1, 32'h12345, 0}, 3);
    run_msg("ind_plain", 1'b0, 1'b0, mk(1, 0, 0, 6'h00, 23'h7FFFFF, 0), 2,
      '{32'h0C, 32'h7FFFFF, 0, 0}, 2);
  endtask

  task automatic t_count();
    run_msg("dir_cnt", 1'b1, 1'b0, mk(0, 0, 0, 6'h00, 23'h000001, 1), 7,
      '{32'h0B, 32'h7, 32'h1, 0}, 3);
    run_msg("ind_cnt", 1'b1, 1'b0, mk(1, 0, 0, 6'h00, 23'h5A5A5, 0), 200,
      '{32'h0C, 32'hC8, 32'h5A5A5, 0}, 3);
    run_msg("exc_cnt", 1'b1, 1'b0, mk(0, 0, 1, 6'h00, 23'h00400, 0), 5,
      '{32'h0B, 32'h4, 32'h400, 0}, 3);
  endtask

  task automatic t_comp();
    run_msg("dir_cmp0", 1'b0, 1'b0, mk(0, 1, 0, 6'h2A, 23'h7FFFFF, 0), 0,
      '{32'h3C, 32'h2A, 32'h7FFFFF, 0}, 3);
    run_msg("ind_cmp0", 1'b0, 1'b0, mk(1, 1, 0, 6'h3F, 23'h000001, 0), 0,
      '{32'h3D, 32'h3F, 32'h1, 0}, 3);
    run_msg("dir_cmp1", 1'b1, 1'b0, mk(0, 1, 0, 6'h15, 23'h2468A, 0), 9,
      '{32'h3C, 32'h9, 32'h15, 32'h2468A}, 4);
    run_msg("ind_cmp1", 1'b1, 1'b0, mk(1, 1, 0, 6'h00, 23'h13579, 0), 1,
      '{32'h3D, 32'h1, 32'h0, 32'h13579}, 4);
  endtask

  task automatic t_full();
    retire(256);
    `PTF_CMP("stall", 1'b1, cnt_stall)
    collect("res_full", '{32'h1B, 32'h0, 0, 0}, 2);
    run_msg("after_full", 1'b1, 1'b0, mk(0, 0, 0, 6'h00, 23'h00077, 0), 3,
      '{32'h0B, 32'h3, 32'h77, 0}, 3);
    $display("test res_full done");
  endtask

  task automatic t_hold();
    run_msg("sel_flip", 1'b1, 1'b1, mk(1, 1, 0, 6'h07, 23'h00ABC, 1), 6,
      '{32'h3D, 32'h6, 32'h7, 32'hABC}, 4);
    run_msg("sel_flip0", 1'b0, 1'b1, mk(0, 0, 0, 6'h00, 23'h00ABC, 0), 6,
      '{32'h0B, 32'h0, 32'hABC, 0}, 3);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held four cycles, then every scenario
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    `PTF_CMP("idle_mseo", 1'b1, mseo_n)
    `PTF_CMP("idle_rdy", 1'b1, ev_rdy)
    t_plain();
    t_count();
    t_comp();
    t_full();
    t_hold();
    summarize();
  end
endmodule

/* File: hw/ptf_formatter.sv */
// Program trace sync message formatter, top level
// Notes on behaviour
// - Select bit set puts instruction count in place of cancelled flag.
// - On exception the count reported is one lower than old modules.
// - Select clear: direct sync is type 11, cancelled bit, address.
// - Select set: direct sync is type 11, count, then address.
// - Select clear: indirect sync is type 12 then address.
// - Select set: indirect sync is type 12, count, then address.
// - Compressed forms add a six bit start bit pointer.
// - Select clear: compressed direct is type 60, pointer, address.
// - Select set: compressed direct is 60, count, pointer, address.
// - Bits shifted out depend on the data-out pin count.
// - Compressed indirect uses type 61, same layout as direct.
// - Count reaching 256 without branch emits a resource full message.
// - Resource full carries code 0000 for count full.
`timescale 1ns/1ns
module ptf_formatter (
  input  wire logic                sys_clk,     // System clock, 250 MHz
  input  wire logic                rst,         // Sync reset, active high
  input  wire logic                sync_count_select, // Layout select
  input  wire logic                instr_retire, // One instruction done
  input  wire logic                ev_vld,      // Sync event offered
  input  wire ptf_pkg::ptf_event_t ev,          // Sync event data
  output logic                     ev_rdy,      // Event taken
  output logic [ptf_pkg::MDO_W-1:0] mdo,        // Message data out
  output logic                     mseo_n,      // Message start/end out
  output logic                     cnt_stall    // Retire must wait
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ptf_pkg::ptf_state_t state;
    logic [1:0]          idx;     // Field being sent
    logic [1:0]          nfld;    // Index of last field
    ptf_pkg::ptf_field_t [ptf_pkg::FIELDS-1:0] flds;
    logic [8:0]          instruction_count;
    logic                sel;     // Select bit latched per message
  } ptf_st_t;

  ptf_st_t st_ff;
  ptf_st_t nxt_st;
  logic    fld_rdy;
  ptf_pkg::ptf_beat_t beat;
  logic    cnt_full;
  logic [7:0] cnt_rep;
  logic [ptf_pkg::FLEN_W-1:0] cnt_len;
  logic [ptf_pkg::FLEN_W-1:0] adr_len;

  // Full count must be flushed as a resource full message first
  assign cnt_full  = st_ff.instruction_count == ptf_pkg::CNT_MAX;
  assign cnt_stall = cnt_full;
  assign ev_rdy    = st_ff.state == ptf_pkg::PTF_IDLE && !cnt_full;
  assign mdo       = beat.data;
  assign mseo_n    = beat.mseo_n;

  // Exception drops the faulting instruction from the count
  always_comb begin
    cnt_rep = st_ff.instruction_count[7:0];
    if (ev.exception && st_ff.instruction_count != 9'h000) begin
      cnt_rep = 8'(st_ff.instruction_count - 9'h001);
    end
  end

  // Significant widths of variable fields, at least one bit
  function automatic logic [ptf_pkg::FLEN_W-1:0] sig_len(
      input logic [ptf_pkg::FLD_W-1:0] v);
    logic [ptf_pkg::FLEN_W-1:0] n;
    n = ptf_pkg::LEN_ONE;
    for (int i = 0; i < ptf_pkg::FLD_W; i++) begin
      if (v[i]) begin
        n = 5'(i + 1);
      end
    end
    return n;
  endfunction

  assign cnt_len = sig_len({15'h0000, cnt_rep});
  assign adr_len = sig_len(ev.target);

  ////////////////////////////////////////////////////////////////////////
  // Message builder and field sequencer
  always_comb begin
    nxt_st = st_ff;
    if (instr_retire && !cnt_full) begin
      nxt_st.instruction_count = st_ff.instruction_count + 9'h001;
    end
    case (st_ff.state)
      ptf_pkg::PTF_IDLE: begin
        nxt_st.idx = 2'h0;
        if (cnt_full) begin
          // Resource full: type 27 then code 0000, count restarts
          nxt_st.flds[0] = '{23'(ptf_pkg::TC_RES_FULL), ptf_pkg::LEN_TC};
          nxt_st.flds[1] = '{23'(ptf_pkg::RC_CNT_FULL),
                             5'(ptf_pkg::RC_W)};
          nxt_st.nfld  = 2'h1;
          nxt_st.instruction_count = instr_retire ? 9'h001 : 9'h000;
          nxt_st.state = ptf_pkg::PTF_SEND;
        end else if (ev_vld) begin
          nxt_st.sel = sync_count_select;
          nxt_st.instruction_count = instr_retire ? 9'h001 : 9'h000;
          nxt_st.flds[0].len = ptf_pkg::LEN_TC;
          // Type code by branch kind and code density
          case ({ev.compressed, ev.indirect})
            2'b00: nxt_st.flds[0].val = 23'(ptf_pkg::TC_DIRECT);
            2'b01: nxt_st.flds[0].val = 23'(ptf_pkg::TC_INDIRECT);
            2'b10: nxt_st.flds[0].val = 23'(ptf_pkg::TC_DIR_CMP);
            2'b11: nxt_st.flds[0].val = 23'(ptf_pkg::TC_IND_CMP);
            default: nxt_st.flds[0].val = '0;
          endcase
          if (sync_count_select) begin
            // Count replaces the cancelled flag
            nxt_st.flds[1] = '{23'(cnt_rep), cnt_len};
            if (ev.compressed) begin
              nxt_st.flds[2] = '{23'(ev.bit_ptr),
                                 ptf_pkg::LEN_BP};
              nxt_st.flds[3] = '{ev.target, adr_len};
              nxt_st.nfld    = 2'h3;
            end else begin
              nxt_st.flds[2] = '{ev.target, adr_len};
              nxt_st.nfld    = 2'h2;
            end
          end else if (ev.compressed) begin
            nxt_st.flds[1] = '{23'(ev.bit_ptr), ptf_pkg::LEN_BP};
            nxt_st.flds[2] = '{ev.target, adr_len};
            nxt_st.nfld    = 2'h2;
          end else if (!ev.indirect) begin
            nxt_st.flds[1] = '{23'(ev.cancelled), ptf_pkg::LEN_ONE};
            nxt_st.flds[2] = '{ev.target, adr_len};
            nxt_st.nfld    = 2'h2;
          end else begin
            nxt_st.flds[1] = '{ev.target, adr_len};
            nxt_st.nfld    = 2'h1;
          end
          nxt_st.state = ptf_pkg::PTF_SEND;
        end
      end
      ptf_pkg::PTF_SEND: begin
        if (fld_rdy) begin
          if (st_ff.idx == st_ff.nfld) begin
            nxt_st.state = ptf_pkg::PTF_LAST;
          end else begin
            nxt_st.idx = st_ff.idx + 2'h1;
          end
        end
      end
      ptf_pkg::PTF_LAST: begin
        // Wait for the final field to drain before idling
        if (fld_rdy) begin
          nxt_st.state = ptf_pkg::PTF_IDLE;
        end
      end
      default: nxt_st.state = ptf_pkg::PTF_IDLE;
    endcase
  end

  // Register the state copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin packing depends on the data-out width
  ptf_shifter u_shift (
    .sys_clk (sys_clk),
    .rst     (rst),
    .fld_vld (st_ff.state == ptf_pkg::PTF_SEND),
    .fld     (st_ff.flds[st_ff.idx]),
    .fld_end (st_ff.idx == st_ff.nfld),
    .fld_rdy (fld_rdy),
    .beat    (beat)
  );

  ////////////////////////////////////////////////////////////////////////
  chk_count_cap: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.instruction_count <= ptf_pkg::CNT_MAX)
    else $error("instruction count passed its cap");
  chk_full_msg: assert property (@(posedge sys_clk) disable iff (rst)
    cnt_full && st_ff.state == ptf_pkg::PTF_IDLE |=>
    st_ff.flds[0].val == 23'(ptf_pkg::TC_RES_FULL) &&
    st_ff.flds[1].val == 23'(ptf_pkg::RC_CNT_FULL))
    else $error("resource full message malformed");
  chk_sel_hold: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.state != ptf_pkg::PTF_IDLE |=> $stable(st_ff.sel))
    else $error("layout select changed mid message");
  chk_cnt_field: assert property (@(posedge sys_clk) disable iff (rst)
    ev_vld && ev_rdy && sync_count_select && !ev.exception |=>
    st_ff.flds[1].val == 23'($past(st_ff.instruction_count[7:0])))
    else $error("count field not placed");
  chk_exc_minus: assert property (@(posedge sys_clk) disable iff (rst)
    ev_vld && ev_rdy && sync_count_select && ev.exception &&
    st_ff.instruction_count != 9'h000 |=>
    st_ff.flds[1].val == 23'($past(st_ff.instruction_count) - 9'h001))
    else $error("exception count not reduced by one");
  chk_dir_plain: assert property (@(posedge sys_clk) disable iff (rst)
    ev_vld && ev_rdy && !sync_count_select && !ev.compressed &&
    !ev.indirect |=> st_ff.flds[0].val == 23'h00000B &&
    st_ff.flds[1].len == 5'h01 && st_ff.nfld == 2'h2)
    else $error("direct sync layout wrong");
  chk_ind_plain: assert property (@(posedge sys_clk) disable iff (rst)
    ev_vld && ev_rdy && !sync_count_select && !ev.compressed &&
    ev.indirect |=> st_ff.flds[0].val == 23'h00000C &&
    st_ff.nfld == 2'h1)
    else $error("indirect sync layout wrong");
  chk_cmp_ptr: assert property (@(posedge sys_clk) disable iff (rst)
    ev_vld && ev_rdy && ev.compressed && sync_count_select |=>
    st_ff.flds[2].len == 5'h06 && st_ff.nfld == 2'h3)
    else $error("compressed pointer misplaced");
  chk_cmp_code: assert property (@(posedge sys_clk) disable iff (rst)
    ev_vld && ev_rdy && ev.compressed && ev.indirect |=>
    st_ff.flds[0].val == 23'h00003D)
    else $error("compressed indirect code wrong");
  chk_msg_ends: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.state == ptf_pkg::PTF_SEND |-> ##[1:40]
    st_ff.state == ptf_pkg::PTF_IDLE)
    else $error("message never finished");

  cov_full_msg: cover property (@(posedge sys_clk) cnt_full);
  cov_cmp_cnt: cover property (@(posedge sys_clk)
    ev_vld && ev_rdy && ev.compressed && sync_count_select);
  cov_plain: cover property (@(posedge sys_clk)
    ev_vld && ev_rdy && !sync_count_select);
endmodule

/* File: hw/ptf_pkg.sv */
// Package for the program trace sync message formatter
package ptf_pkg;
  localparam int MDO_W      = 8;       // Message data-out pin count
  localparam int ADDR_W     = 23;      // Full target address width
  localparam int CNT_W      = 8;       // Instruction count field width
  localparam int BP_W       = 6;       // Bit pointer width
  localparam int TC_W       = 6;       // Type code width
  localparam int RC_W       = 4;       // Resource code width
  localparam int FLD_W      = 23;      // Widest field
  localparam int FLEN_W     = 5;       // Width of a field length
  localparam int FIELDS     = 4;       // Most fields in one message

  localparam logic [TC_W-1:0] TC_DIRECT   = 6'h0B;
  localparam logic [TC_W-1:0] TC_INDIRECT = 6'h0C;
  localparam logic [TC_W-1:0] TC_RES_FULL = 6'h1B;
  localparam logic [TC_W-1:0] TC_DIR_CMP  = 6'h3C;
  localparam logic [TC_W-1:0] TC_IND_CMP  = 6'h3D;
  localparam logic [RC_W-1:0] RC_CNT_FULL = 4'h0;

  localparam logic [8:0] CNT_MAX   = 9'h100;  // 256 instructions
  localparam logic [FLEN_W-1:0] LEN_TC  = 5'h06;
  localparam logic [FLEN_W-1:0] LEN_BP  = 5'h06;
  localparam logic [FLEN_W-1:0] LEN_ONE = 5'h01;

  // Trace event from the core
  typedef struct packed {
    logic              indirect;   // Indirect branch, else direct
    logic              compressed; // Compressed code
    logic              exception;  // Event caused by an exception
    logic [BP_W-1:0]   bit_ptr;    // Start bit within word
    logic [ADDR_W-1:0] target;     // Full target address
    logic              cancelled;  // Messages cancelled flag
  } ptf_event_t;

  // One output beat on the data-out pins
  typedef struct packed {
    logic [MDO_W-1:0] data;
    logic             mseo_n;      // Low inside a field
  } ptf_beat_t;

  // One field to be shifted out
  typedef struct packed {
    logic [FLD_W-1:0]  val;
    logic [FLEN_W-1:0] len;
  } ptf_field_t;

  typedef enum logic [1:0] {
    PTF_IDLE = 2'b00,
    PTF_SEND = 2'b01,
    PTF_LAST = 2'b11
  } ptf_state_t;
endpackage

/* File: hw/ptf_shifter.sv */
// Field shifter: packs message fields onto the data-out pins
`timescale 1ns/1ns
module ptf_shifter (
  input  wire logic                sys_clk,  // System clock
  input  wire logic                rst,      // Sync reset, active high
  input  wire logic                fld_vld,  // Field offered
  input  wire ptf_pkg::ptf_field_t fld,      // Field value and length
  input  wire logic                fld_end,  // Field ends the message
  output logic                     fld_rdy,  // Field taken
  output ptf_pkg::ptf_beat_t       beat      // Pin beat
);
  typedef struct packed {
    logic [ptf_pkg::FLD_W-1:0]  val;
    logic [ptf_pkg::FLEN_W-1:0] left;
    logic                       last;
    logic                       busy;
    ptf_pkg::ptf_beat_t         beat;
  } ptf_shst_t;

  ptf_shst_t st_ff;
  ptf_shst_t nxt_st;

  // Take a new field only when the previous one has fully left
  assign fld_rdy = !st_ff.busy;
  assign beat    = st_ff.beat;

  // Each field starts on a fresh beat; mseo_n marks field end
  always_comb begin
    nxt_st = st_ff;
    nxt_st.beat.data   = '0;
    nxt_st.beat.mseo_n = 1'b1;
    if (st_ff.busy) begin
      nxt_st.beat.data = st_ff.val[ptf_pkg::MDO_W-1:0];
      nxt_st.val = st_ff.val >> ptf_pkg::MDO_W;
      if (st_ff.left <= 5'(ptf_pkg::MDO_W)) begin
        nxt_st.busy = 1'b0;
        nxt_st.left = '0;
        // Final beat of the field; the idle beat follows on the next cycle, with or without a load
        nxt_st.beat.mseo_n = 1'b0;
      end else begin
        nxt_st.left = st_ff.left - 5'(ptf_pkg::MDO_W);
        nxt_st.beat.mseo_n = 1'b0;
      end
    end else if (fld_vld) begin
      nxt_st.val  = fld.val;
      nxt_st.left = fld.len;
      nxt_st.last = fld_end;
      nxt_st.busy = 1'b1;
    end
  end

  // Register the state copy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.beat.mseo_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // A beat inside a field always has mseo_n low
  chk_shift_beat: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.busy |=> !beat.mseo_n)
    else $error("beat not marked during field");

  // After the closing field of a message the pins fall back to idle
  chk_last_idle: assert property (@(posedge sys_clk) disable iff (rst)
    st_ff.busy && st_ff.last && st_ff.left <= 5'(ptf_pkg::MDO_W) |=>
    ##1 beat.mseo_n)
    else $error("pins not idle after message end");
endmodule
